// ===== hw/pse_regs.sv
// Per-port symbol error counter and special control/status register bank.
// Assumes a plain strobe register port on core_clk_i, receiver status from
// the same clock, and the fiber strap as an asynchronous pin.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module pse_regs #(
   parameter int unsigned CNT_W = pse_pkg::DATA_W
) (
   input  wire logic                          core_clk_i,
   input  wire logic                          rst_b_i,
   input  wire logic [pse_pkg::ADDR_W-1:0]    reg_addr_i,
   input  wire logic [pse_pkg::DATA_W-1:0]    reg_wdata_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   output logic      [pse_pkg::DATA_W-1:0]    reg_rdata_o,
   input  pse_pkg::pse_rx_t                   rx_i,
   input  wire logic                          phy_reset_i,
   input  wire logic                          soft_reset_i,
   input  wire logic                          fiber_strap_i,
   output logic                               xo_auto_o,
   output logic                               xo_cross_o,
   output logic                               heartbeat_en_o,
   output logic                               fefi_gen_en_o,
   output logic                               fefi_det_en_o,
   output logic                               irq_o
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // Indices that match none of the compares are dropped on write and
   // read back as zero, so the bank tolerates a sparse index space.
   function automatic logic idx_hit(
      input logic [pse_pkg::ADDR_W-1:0] addr,
      input logic [pse_pkg::ADDR_W-1:0] idx
   );
      idx_hit = (addr == idx);
   endfunction

   logic wr_spcs;
   logic wr_stat;
   logic wr_mask;
   logic rd_cnt;
   logic rd_spcs;
   logic rd_stat;
   logic rd_mask;

   assign wr_spcs = reg_wr_i && idx_hit(reg_addr_i, pse_pkg::SPCS_IDX);
   assign wr_stat = reg_wr_i && idx_hit(reg_addr_i, pse_pkg::IRQ_STAT_IDX);
   assign wr_mask = reg_wr_i && idx_hit(reg_addr_i, pse_pkg::IRQ_MASK_IDX);
   assign rd_cnt  = reg_rd_i && idx_hit(reg_addr_i, pse_pkg::SYM_ERR_IDX);
   assign rd_spcs = reg_rd_i && idx_hit(reg_addr_i, pse_pkg::SPCS_IDX);
   assign rd_stat = reg_rd_i && idx_hit(reg_addr_i, pse_pkg::IRQ_STAT_IDX);
   assign rd_mask = reg_rd_i && idx_hit(reg_addr_i, pse_pkg::IRQ_MASK_IDX);

   // ----------------------------------------------------------------
   // Fiber strap synchroniser and capture after reset release
   // ----------------------------------------------------------------
   logic                strap_meta_q;
   logic                strap_sync_q;
   pse_pkg::pse_init_t  init_q;
   pse_pkg::pse_init_t  init_d;
   logic                strap_load;
   logic                strap_aged_q;

   // The aged flag marks the first edge after release, the one at which
   // the first synchroniser stage takes the pin for the first time.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         strap_meta_q <= 1'b0;
         strap_sync_q <= 1'b0;
         strap_aged_q <= 1'b0;
      end else begin
         strap_meta_q <= fiber_strap_i;
         strap_sync_q <= strap_meta_q;
         strap_aged_q <= 1'b1;
      end
   end

   // Two edges pass before the synchronised strap is trusted, so the
   // far end fault default is loaded on the third edge after release.
   // Loading any earlier would capture the reset value of the second
   // stage instead of the pin, and fiber ports would start with it off.
   always_comb begin
      init_d = init_q;
      unique case (init_q)
         pse_pkg::PSE_INIT_SYNC: begin
            if (strap_aged_q) begin
               init_d = pse_pkg::PSE_INIT_LOAD;
            end
         end
         pse_pkg::PSE_INIT_LOAD: init_d = pse_pkg::PSE_INIT_RUN;
         pse_pkg::PSE_INIT_RUN:  init_d = pse_pkg::PSE_INIT_RUN;
         default:                init_d = pse_pkg::PSE_INIT_SYNC;
      endcase
   end

   assign strap_load = (init_q == pse_pkg::PSE_INIT_LOAD);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         init_q <= pse_pkg::PSE_INIT_SYNC;
      end else begin
         init_q <= init_d;
      end
   end

   // ----------------------------------------------------------------
   // Symbol error counter
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt;
   logic             cnt_inc;
   logic             cnt_wrap;
   logic             any_phy_reset;

   // Both reset pulses clear the count; the pulse also wins over an
   // increment in the same cycle, so the count always restarts at zero.
   assign any_phy_reset = phy_reset_i || soft_reset_i;

   // The counter has no write path at all, so stray writes to its index
   // cannot disturb it.
   pse_sym_counter #(
      .WIDTH (CNT_W)
   ) u_counter (
      .core_clk_i  (core_clk_i),
      .rst_b_i     (rst_b_i),
      .clr_i       (any_phy_reset),
      .err_i       (rx_i.sym_err),
      .rx_active_i (rx_i.rx_active),
      .hold_i      (rx_i.speed_10),
      .count_o     (cnt),
      .inc_o       (cnt_inc),
      .wrap_o      (cnt_wrap)
   );

   // ----------------------------------------------------------------
   // Special control/status register
   // ----------------------------------------------------------------
   pse_pkg::pse_ctrl_t ctrl_q;
   pse_pkg::pse_ctrl_t ctrl_d;
   pse_pkg::pse_ctrl_t ctrl_rst;
   logic               fefi_q;
   logic               fefi_d;
   logic               pol_q;

   assign ctrl_rst = '{src:     pse_pkg::XO_BIT_RST,
                       auto_en: pse_pkg::XO_BIT_RST,
                       state:   pse_pkg::XO_BIT_RST,
                       sqe_off: pse_pkg::SQE_OFF_RST};

   // Soft reset leaves the crossover and heartbeat bits alone; only the
   // reset control path clears them.
   assign ctrl_d = phy_reset_i ? ctrl_rst :
                   wr_spcs ? '{src:     reg_wdata_i[pse_pkg::XO_SRC_BIT],
                               auto_en: reg_wdata_i[pse_pkg::XO_EN_BIT],
                               state:   reg_wdata_i[pse_pkg::XO_ST_BIT],
                               sqe_off: reg_wdata_i[pse_pkg::SQE_OFF_BIT]}
                           : ctrl_q;

   // Far end fault is not immune to soft reset and returns to the
   // strap-derived default on every kind of reset.
   assign fefi_d = (strap_load || any_phy_reset) ? strap_sync_q :
                   wr_spcs ? reg_wdata_i[pse_pkg::FEFI_BIT] :
                   fefi_q;

   // The polarity copy is status only: it is refreshed on every edge and
   // a write to its position is discarded.
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_q <= '0;
         fefi_q <= pse_pkg::FEFI_PRE_RST;
         pol_q  <= pse_pkg::POL_RST;
      end else begin
         ctrl_q <= ctrl_d;
         fefi_q <= fefi_d;
         pol_q  <= rx_i.pol_rev;
      end
   end

   // ----------------------------------------------------------------
   // Crossover, heartbeat and far end fault outputs
   // ----------------------------------------------------------------
   pse_pkg::pse_xo_mode_t xo_mode;
   logic                  xo_auto_q;
   logic                  xo_cross_q;
   logic                  hb_en_q;
   logic                  fefi_out_q;

   // Registering every control output costs one cycle after a write but
   // keeps decode glitches away from the line interface.
   pse_mdix_decode u_mdix (
      .ctrl_i (ctrl_q),
      .mode_o (xo_mode)
   );

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         xo_auto_q  <= 1'b1;
         xo_cross_q <= 1'b0;
         hb_en_q    <= 1'b1;
         fefi_out_q <= 1'b0;
      end else begin
         xo_auto_q  <= (xo_mode == pse_pkg::PSE_XO_AUTO);
         xo_cross_q <= (xo_mode == pse_pkg::PSE_XO_CROSS);
         hb_en_q    <= !ctrl_q.sqe_off;
         fefi_out_q <= fefi_q;
      end
   end

   assign xo_auto_o      = xo_auto_q;
   assign xo_cross_o     = xo_cross_q;
   assign heartbeat_en_o = hb_en_q;
   assign fefi_gen_en_o  = fefi_out_q;
   assign fefi_det_en_o  = fefi_out_q;

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   logic [pse_pkg::IRQ_W-1:0] irq_stat_q;
   logic [pse_pkg::IRQ_W-1:0] irq_stat_d;
   logic [pse_pkg::IRQ_W-1:0] irq_mask_q;
   logic [pse_pkg::IRQ_W-1:0] irq_set;
   logic [pse_pkg::IRQ_W-1:0] irq_clr;
   logic                      irq_q;

   // A polarity event is any change of the receive polarity level, found
   // by comparing the input with its copy from the cycle before.
   assign irq_set[pse_pkg::IRQ_INC_BIT]  = cnt_inc;
   assign irq_set[pse_pkg::IRQ_WRAP_BIT] = cnt_wrap;
   assign irq_set[pse_pkg::IRQ_POL_BIT]  = rx_i.pol_rev ^ pol_q;

   // The mask gates only the output: status bits latch whether or not
   // their source is enabled, so software can poll with the line masked.
   assign irq_clr = wr_stat ? reg_wdata_i[pse_pkg::IRQ_W-1:0] : '0;

   // A new event in the same cycle as its clear keeps the bit set.
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat_q <= pse_pkg::IRQ_RST;
         irq_mask_q <= pse_pkg::IRQ_RST;
         irq_q      <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= wr_mask ? reg_wdata_i[pse_pkg::IRQ_W-1:0]
                               : irq_mask_q;
         irq_q      <= |(irq_stat_d & irq_mask_q);
      end
   end

   assign irq_o = irq_q;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [pse_pkg::DATA_W-1:0] spcs_view;
   logic [pse_pkg::DATA_W-1:0] cnt_view;
   logic [pse_pkg::DATA_W-1:0] stat_view;
   logic [pse_pkg::DATA_W-1:0] mask_view;
   logic [pse_pkg::DATA_W-1:0] rdata_d;
   logic [pse_pkg::DATA_W-1:0] rdata_q;

   // Reserved positions are built as constant zero, so writes never
   // reach them.
   always_comb begin
      spcs_view                       = '0;
      spcs_view[pse_pkg::XO_SRC_BIT]  = ctrl_q.src;
      spcs_view[pse_pkg::XO_EN_BIT]   = ctrl_q.auto_en;
      spcs_view[pse_pkg::XO_ST_BIT]   = ctrl_q.state;
      spcs_view[pse_pkg::SQE_OFF_BIT] = ctrl_q.sqe_off;
      spcs_view[pse_pkg::FEFI_BIT]    = fefi_q;
      spcs_view[pse_pkg::POL_BIT]     = pol_q;
   end

   assign cnt_view  = pse_pkg::DATA_W'(cnt);
   assign stat_view = pse_pkg::DATA_W'(irq_stat_q);
   assign mask_view = pse_pkg::DATA_W'(irq_mask_q);

   // Reading the counter has no side effect on it.
   assign rdata_d = rd_cnt  ? cnt_view  :
                    rd_spcs ? spcs_view :
                    rd_stat ? stat_view :
                    rd_mask ? mask_view :
                    pse_pkg::SYM_ERR_RST;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Read data fall back to zero outside the answer cycle, so a stale
   // value is never mistaken for a fresh read.
   assign reg_rdata_o = rdata_q;

endmodule // pse_regs

// ===== hw/pse_pkg.sv
// Shared constants and types for the symbol error and crossover register bank.
// Assumes a single core clock domain and a plain strobe register port.
package pse_pkg;

   // ----------------------------------------------------------------
   // Register port geometry and register indices
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned IRQ_W  = 3;

   localparam logic [ADDR_W-1:0] SYM_ERR_IDX  = 6'h1a;
   localparam logic [ADDR_W-1:0] SPCS_IDX     = 6'h1b;
   localparam logic [ADDR_W-1:0] IRQ_STAT_IDX = 6'h20;
   localparam logic [ADDR_W-1:0] IRQ_MASK_IDX = 6'h21;

   // ----------------------------------------------------------------
   // Field positions of the special control/status register
   // ----------------------------------------------------------------
   localparam int unsigned XO_SRC_BIT  = 15;
   localparam int unsigned XO_EN_BIT   = 14;
   localparam int unsigned XO_ST_BIT   = 13;
   localparam int unsigned SQE_OFF_BIT = 11;
   localparam int unsigned FEFI_BIT    = 5;
   localparam int unsigned POL_BIT     = 4;

   // ----------------------------------------------------------------
   // Interrupt status and mask bit positions
   // ----------------------------------------------------------------
   localparam int unsigned IRQ_INC_BIT  = 0;
   localparam int unsigned IRQ_WRAP_BIT = 1;
   localparam int unsigned IRQ_POL_BIT  = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] SYM_ERR_RST  = 16'h0000;
   localparam logic [IRQ_W-1:0]  IRQ_RST      = 3'h0;
   localparam logic              XO_BIT_RST   = 1'b0;
   localparam logic              SQE_OFF_RST  = 1'b0;
   localparam logic              FEFI_PRE_RST = 1'b0;
   localparam logic              POL_RST      = 1'b0;

   typedef enum logic [1:0] {
      PSE_XO_STRAIGHT,
      PSE_XO_CROSS,
      PSE_XO_AUTO
   } pse_xo_mode_t;

   typedef enum logic [1:0] {
      PSE_INIT_SYNC,
      PSE_INIT_LOAD,
      PSE_INIT_RUN
   } pse_init_t;

   typedef struct packed {
      logic sym_err;
      logic rx_active;
      logic speed_10;
      logic pol_rev;
   } pse_rx_t;

   typedef struct packed {
      logic src;
      logic auto_en;
      logic state;
      logic sqe_off;
   } pse_ctrl_t;

endpackage

// ===== hw/pse_sym_counter.sv
// Receive symbol error counter, one count at most per packet.
// Assumes the error strobe and packet level come from the core clock domain.
`timescale 1ns/1ps
module pse_sym_counter #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             clr_i,
   input  wire logic             err_i,
   input  wire logic             rx_active_i,
   input  wire logic             hold_i,
   output logic      [WIDTH-1:0] count_o,
   output logic                  inc_o,
   output logic                  wrap_o
);

   logic             counted_q;
   logic             counted_d;
   logic [WIDTH-1:0] count_q;
   logic             bump;

   assign bump      = err_i && !counted_q && !hold_i;
   assign counted_d = rx_active_i && (counted_q || bump);
   assign count_o   = count_q;
   assign inc_o     = bump;
   assign wrap_o    = bump && (&count_q);

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_q   <= '0;
         counted_q <= 1'b0;
      end else if (clr_i) begin
         count_q   <= '0;
         counted_q <= 1'b0;
      end else begin
         count_q   <= count_q + WIDTH'(bump);
         counted_q <= counted_d;
      end
   end

endmodule // pse_sym_counter

// ===== hw/pse_mdix_decode.sv
// Crossover mode decode from the control source, enable and state bits.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pse_mdix_decode (
   input  pse_pkg::pse_ctrl_t   ctrl_i,
   output pse_pkg::pse_xo_mode_t mode_o
);

   logic [1:0] sel;

   assign sel = {ctrl_i.auto_en, ctrl_i.state};

   // The reserved code 11 falls back to automatic detection, the
   // least harmful choice if software misprograms the pair.
   assign mode_o = !ctrl_i.src ? pse_pkg::PSE_XO_AUTO :
                   (sel == 2'b00) ? pse_pkg::PSE_XO_STRAIGHT :
                   (sel == 2'b01) ? pse_pkg::PSE_XO_CROSS :
                   pse_pkg::PSE_XO_AUTO;

endmodule // pse_mdix_decode

// ===== verif/pse_regs_props.sv
// Checker for the symbol error and crossover register bank.
// Assumes it is bound to pse_regs and sees only its ports.
`timescale 1ns/1ps
module pse_regs_props #(
   parameter int unsigned CNT_W = 16
) (
   input wire logic                 core_clk_i,
   input wire logic                 rst_b_i,
   input wire logic [5:0]           reg_addr_i,
   input wire logic [15:0]          reg_wdata_i,
   input wire logic                 reg_wr_i,
   input wire logic                 reg_rd_i,
   input wire logic [15:0]          reg_rdata_o,
   input pse_pkg::pse_rx_t          rx_i,
   input wire logic                 phy_reset_i,
   input wire logic                 soft_reset_i,
   input wire logic                 fiber_strap_i,
   input wire logic                 xo_auto_o,
   input wire logic                 xo_cross_o,
   input wire logic                 heartbeat_en_o,
   input wire logic                 fefi_gen_en_o,
   input wire logic                 fefi_det_en_o,
   input wire logic                 irq_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // Reset pulses are kept out so that only the written value decides.
   sequence spcs_wr;
      reg_wr_i && reg_addr_i == pse_pkg::SPCS_IDX && !phy_reset_i &&
      !soft_reset_i ##1 !phy_reset_i && !soft_reset_i;
   endsequence

   a_auto_select: assert property (spcs_wr |=> xo_auto_o ==
      (!$past(reg_wdata_i[15], 2) || $past(reg_wdata_i[14], 2)))
      else $error("automatic crossover output wrong after write");
   a_manual_cross: assert property (spcs_wr |=> xo_cross_o ==
      ($past(reg_wdata_i[15], 2) && !$past(reg_wdata_i[14], 2) &&
      $past(reg_wdata_i[13], 2)))
      else $error("forced crossover output wrong after write");
   a_heartbeat_ctl: assert property (spcs_wr |=>
      heartbeat_en_o == !$past(reg_wdata_i[11], 2))
      else $error("heartbeat enable does not follow its disable bit");
   a_fefi_both_ways: assert property (spcs_wr |=>
      fefi_gen_en_o == $past(reg_wdata_i[5], 2) &&
      fefi_det_en_o == $past(reg_wdata_i[5], 2))
      else $error("far end fault enables do not follow bit 5");
   a_fefi_reload: assert property ((phy_reset_i || soft_reset_i) &&
      !reg_wr_i ##1 !reg_wr_i |=> fefi_gen_en_o == fiber_strap_i)
      else $error("far end fault enable not reloaded from strap");
   a_phy_clear: assert property (phy_reset_i && !reg_wr_i ##1
      !reg_wr_i |=> xo_auto_o && !xo_cross_o && heartbeat_en_o)
      else $error("phy reset did not clear crossover and heartbeat bits");
   a_reserved_zero: assert property (reg_rd_i &&
      reg_addr_i == pse_pkg::SPCS_IDX |=> (reg_rdata_o & 16'h17cf) == 0)
      else $error("reserved control bits read nonzero");
   a_polarity_bit: assert property (reg_rd_i &&
      reg_addr_i == pse_pkg::SPCS_IDX && $stable(rx_i.pol_rev) |=>
      reg_rdata_o[4] == $past(rx_i.pol_rev))
      else $error("polarity bit does not report receive polarity");

   c_spcs_write: cover property (spcs_wr);
   c_phy_reset: cover property (phy_reset_i);
   c_irq_high: cover property ($rose(irq_o));
endmodule // pse_regs_props

bind pse_regs pse_regs_props #(.CNT_W(CNT_W)) pse_regs_props_inst (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .rx_i(rx_i), .phy_reset_i(phy_reset_i),
   .soft_reset_i(soft_reset_i), .fiber_strap_i(fiber_strap_i),
   .xo_auto_o(xo_auto_o), .xo_cross_o(xo_cross_o),
   .heartbeat_en_o(heartbeat_en_o), .fefi_gen_en_o(fefi_gen_en_o),
   .fefi_det_en_o(fefi_det_en_o), .irq_o(irq_o));

// ===== verif/pse_rx_model.sv
// Model of the receive line activity seen from the cable partner.
// Assumes commands from the bench, changed just after a rising edge.
`timescale 1ns/1ps
module pse_rx_model (
   input  wire logic        core_clk_i,
   input  wire logic        pkt_i,
   input  wire logic [3:0]  n_err_i,
   input  wire logic        stream_i,
   input  wire logic        speed_10_i,
   input  wire logic        pol_rev_i,
   output pse_pkg::pse_rx_t rx_o,
   output logic             busy_o
);
   logic [3:0] left_q = 4'h0;
   logic [3:0] err_q  = 4'h0;

   assign busy_o = left_q != 4'h0;
   always @(posedge core_clk_i) begin
      if (pkt_i) begin
         left_q <= 4'h8;
         err_q  <= n_err_i;
      end else if (busy_o) begin
         left_q <= left_q - 4'h1;
         err_q  <= (err_q != 4'h0) ? err_q - 4'h1 : 4'h0;
      end
   end
   // Errors sit at the head of an eight cycle packet; streamed errors
   // arrive on an idle line, where each one is a fresh event.
   assign rx_o.rx_active = busy_o;
   assign rx_o.sym_err   = busy_o ? (err_q != 4'h0) : stream_i;
   assign rx_o.speed_10  = speed_10_i;
   assign rx_o.pol_rev   = pol_rev_i;
endmodule // pse_rx_model

// ===== verif/tb_pse_regs.sv
// Self-checking bench for the symbol error and crossover register bank.
// Assumes the design files, the checker and the receive model compiled.
`timescale 1ns/1ps
module tb_pse_regs;
   logic             core_clk_i    = 1'b0;
   logic             rst_b_i       = 1'b0;
   logic [5:0]       reg_addr_i    = 6'h00;
   logic [15:0]      reg_wdata_i   = 16'h0000;
   logic             reg_wr_i      = 1'b0;
   logic             reg_rd_i      = 1'b0;
   logic             phy_reset_i   = 1'b0;
   logic             soft_reset_i  = 1'b0;
   logic             fiber_strap_i = 1'b0;
   logic             pkt           = 1'b0;
   logic             stream        = 1'b0;
   logic             speed_10      = 1'b0;
   logic             pol_rev       = 1'b0;
   logic [3:0]       n_err         = 4'h0;
   logic [15:0]      reg_rdata_o;
   pse_pkg::pse_rx_t rx_i;
   logic             busy;
   logic             xo_auto_o;
   logic             xo_cross_o;
   logic             heartbeat_en_o;
   logic             fefi_gen_en_o;
   logic             fefi_det_en_o;
   logic             irq_o;
   int               errors        = 0;
   int               total_checks  = 0;
   int               cycles        = 0;

   pse_regs pse_regs_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .rx_i(rx_i), .phy_reset_i(phy_reset_i), .soft_reset_i(soft_reset_i),
      .fiber_strap_i(fiber_strap_i), .xo_auto_o(xo_auto_o),
      .xo_cross_o(xo_cross_o), .heartbeat_en_o(heartbeat_en_o),
      .fefi_gen_en_o(fefi_gen_en_o), .fefi_det_en_o(fefi_det_en_o),
      .irq_o(irq_o));
   pse_rx_model pse_rx_model_inst (.core_clk_i(core_clk_i), .pkt_i(pkt),
      .n_err_i(n_err), .stream_i(stream), .speed_10_i(speed_10),
      .pol_rev_i(pol_rev), .rx_o(rx_i), .busy_o(busy));

   always #2.5 core_clk_i = ~core_clk_i;

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // The wrap test alone needs some 65,540 cycles.
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 90000) begin
         errors++;
         conclude();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [5:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask
   task automatic settle();
      repeat (2) @(posedge core_clk_i);
      #1;
   endtask
   task automatic packet(input logic [3:0] n);
      @(posedge core_clk_i);
      pkt   <= 1'b1;
      n_err <= n;
      @(posedge core_clk_i);
      pkt <= 1'b0;
      repeat (10) @(posedge core_clk_i);
   endtask
   task automatic errs(input int n);
      @(posedge core_clk_i);
      stream <= 1'b1;
      repeat (n) @(posedge core_clk_i);
      stream <= 1'b0;
   endtask

   task automatic t_reset_values();
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0000);
      rchk(pse_pkg::SPCS_IDX, 16'h0000);
      rchk(pse_pkg::IRQ_STAT_IDX, 16'h0000);
      rchk(6'h3f, 16'h0000);
      chk({xo_auto_o, xo_cross_o, heartbeat_en_o}, 16'h0005);
      $display("test reset values done");
   endtask
   task automatic t_counter();
      packet(4'h3);
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0001);
      packet(4'h0);
      errs(3);
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0004);
      speed_10 <= 1'b1;
      packet(4'h2);
      errs(2);
      speed_10 <= 1'b0;
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0004);
      wr(pse_pkg::SYM_ERR_IDX, 16'h1234);
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0004);
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0004);
      rchk(pse_pkg::IRQ_STAT_IDX, 16'h0001);
      chk(16'(irq_o), 16'h0000);
      wr(pse_pkg::IRQ_MASK_IDX, 16'h0001);
      settle();
      chk(16'(irq_o), 16'h0001);
      wr(pse_pkg::IRQ_STAT_IDX, 16'h0001);
      settle();
      chk(16'(irq_o), 16'h0000);
      $display("test counter done");
   endtask
   task automatic t_wrap();
      errs(65531);
      rchk(pse_pkg::SYM_ERR_IDX, 16'hffff);
      errs(1);
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0000);
      rchk(pse_pkg::IRQ_STAT_IDX, 16'h0003);
      wr(pse_pkg::IRQ_STAT_IDX, 16'h0003);
      $display("test wrap done");
   endtask
   task automatic t_crossover();
      logic [15:0] w [5] = '{16'h0000, 16'h6000, 16'h8000, 16'ha000,
                             16'hc000};
      logic [1:0]  o [5] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b10};
      // The reserved manual pair is never written.
      for (int i = 0; i < 5; i++) begin
         wr(pse_pkg::SPCS_IDX, w[i]);
         settle();
         chk({xo_auto_o, xo_cross_o}, o[i]);
         rchk(pse_pkg::SPCS_IDX, w[i]);
      end
      wr(pse_pkg::SPCS_IDX, 16'h9fff);
      rchk(pse_pkg::SPCS_IDX, 16'h8820);
      chk({heartbeat_en_o, fefi_gen_en_o, fefi_det_en_o}, 16'h0003);
      wr(pse_pkg::SPCS_IDX, 16'h0000);
      settle();
      chk({heartbeat_en_o, fefi_gen_en_o, fefi_det_en_o}, 16'h0004);
      $display("test crossover done");
   endtask
   task automatic t_resets();
      fiber_strap_i <= 1'b1;
      wr(pse_pkg::SPCS_IDX, 16'ha800);
      errs(2);
      @(posedge core_clk_i);
      soft_reset_i <= 1'b1;
      @(posedge core_clk_i);
      soft_reset_i <= 1'b0;
      settle();
      chk({xo_cross_o, heartbeat_en_o, fefi_gen_en_o}, 16'h0005);
      rchk(pse_pkg::SYM_ERR_IDX, 16'h0000);
      rchk(pse_pkg::SPCS_IDX, 16'ha820);
      @(posedge core_clk_i);
      phy_reset_i <= 1'b1;
      @(posedge core_clk_i);
      phy_reset_i <= 1'b0;
      settle();
      chk({xo_auto_o, xo_cross_o, heartbeat_en_o}, 16'h0005);
      rchk(pse_pkg::SPCS_IDX, 16'h0020);
      wr(pse_pkg::IRQ_STAT_IDX, 16'h0007);
      rst_b_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rchk(pse_pkg::SPCS_IDX, 16'h0020);
      $display("test resets done");
   endtask
   task automatic t_polarity();
      pol_rev <= 1'b1;
      settle();
      rchk(pse_pkg::SPCS_IDX, 16'h0030);
      rchk(pse_pkg::IRQ_STAT_IDX, 16'h0004);
      pol_rev <= 1'b0;
      settle();
      rchk(pse_pkg::SPCS_IDX, 16'h0020);
      $display("test polarity done");
   endtask

   initial begin
      repeat (16) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      t_reset_values();
      t_counter();
      t_wrap();
      t_crossover();
      t_resets();
      t_polarity();
      conclude();
   end
endmodule // tb_pse_regs
